// [rx_hub_pkg.sv]
package rx_hub_pkg;
  // ==========================================================
  // Structure
  localparam int NPORT = 4;
  localparam int FRAME_BITS = 28;
  localparam int NTX = 2;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADDR_FWD_CTL = 8'h20;
  localparam logic [7:0] ADDR_CSI_CTL = 8'h33;
  localparam logic [7:0] ADDR_PORT_STS = 8'h4D;
  localparam logic [7:0] ADDR_PORT_CFG = 8'h6D;
  localparam logic [7:0] ADDR_PORT_VCDT = 8'h70;
  // ==========================================================
  // Field positions and reset values
  localparam int MODE_LSB = 0;
  localparam int VC_LSB = 6;
  localparam int REPL_BIT = 4;
  localparam logic [7:0] FWD_CTL_RST = 8'h00;
  localparam logic [7:0] CSI_CTL_RST = 8'h0F;
  localparam logic [5:0] DT_RST = 6'h2C;
  // ==========================================================
  // Receive input modes
  typedef enum logic [1:0] {
    twelve_bit_low_freq_mode,
    twelve_bit_high_freq_mode,
    ten_bit_mode,
    mode_spare
  } rx_mode_t;
  localparam rx_mode_t MODE_RST = twelve_bit_low_freq_mode;
  // ==========================================================
  // Frame layout: data then line sync then frame sync
  localparam int SYNC12_LSB = 12;
  localparam int SYNC10_LSB = 10;
  // ==========================================================
  // CSI-2 data types
  localparam logic [5:0] DT_FS = 6'h00;
  localparam logic [5:0] DT_FE = 6'h01;
  localparam logic [5:0] DT_LS = 6'h02;
  localparam logic [5:0] DT_LE = 6'h03;
  localparam logic [5:0] DT_RAW8 = 6'h2A;
  localparam logic [5:0] DT_RAW10 = 6'h2B;
  localparam logic [5:0] DT_YUV422_8 = 6'h1E;
  localparam logic [5:0] DT_YUV420_10 = 6'h19;
  localparam logic [5:0] DT_YUV420_10C = 6'h1D;
  localparam logic [5:0] DT_YUV422_10 = 6'h1F;
  // ==========================================================
  // Back channel and lane figures
  localparam logic [2:0] BC_RATE_2M5 = 3'h1;
  localparam int LANE_MBPS_MAX = 1600;
endpackage : rx_hub_pkg

// [rx_frame_cdc.sv]
`timescale 1ns/100ps
module rx_frame_cdc
  import rx_hub_pkg::*;
#(
  parameter int W = FRAME_BITS
) (
  input wire logic linkClk,
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [W-1:0] inFrame,
  input wire logic inValid,
  output logic [W-1:0] outFrame,
  output logic outStrobe
);
  // ==========================================================
  // Link side: hold the frame and flip a toggle
  logic [W-1:0] hold;
  logic tog;

  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) begin
      hold <= '0;
      tog <= 1'b0;
    end else if (inValid) begin
      hold <= inFrame;
      tog <= ~tog;
    end
  end

  // ==========================================================
  // Core side: three stages, act once stages two and three agree
  logic s1;
  logic s2;
  logic s3;
  logic seen;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      seen <= 1'b0;
      outFrame <= '0;
      outStrobe <= 1'b0;
    end else begin
      s1 <= tog;
      s2 <= s1;
      s3 <= s2;
      outStrobe <= 1'b0;
      if (s2 == s3 && s3 != seen) begin
        seen <= s3;
        outFrame <= hold;
        outStrobe <= 1'b1;
      end
    end
  end
endmodule : rx_frame_cdc

// [rx_csi2_hub.sv]
`timescale 1ns/100ps
module rx_csi2_hub
  import rx_hub_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic linkClk,
  input wire logic [NPORT-1:0][FRAME_BITS-1:0] rxFrame,
  input wire logic [NPORT-1:0] rxFrameValid,
  input wire logic [2:0] modeStrap,
  input wire logic regWrEn,
  input wire logic [7:0] regAddr,
  input wire logic [1:0] regPort,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  output logic tx0Valid,
  output logic tx0IsHeader,
  output logic [31:0] tx0Data,
  output logic tx1Valid,
  output logic tx1IsHeader,
  output logic [31:0] tx1Data,
  output logic [1:0] tx0LaneSel,
  output logic [1:0] tx1LaneSel,
  output logic [2:0] backChanRate
);
  // ==========================================================
  // Decoding helpers
  function automatic logic strapValid(input logic [2:0] code);
    strapValid = code[1:0] != 2'b00;
  endfunction : strapValid

  function automatic rx_mode_t strapMode(input logic [2:0] code);
    case (code[1:0])
      2'b01: strapMode = twelve_bit_low_freq_mode;
      2'b10: strapMode = twelve_bit_high_freq_mode;
      default: strapMode = ten_bit_mode;
    endcase
  endfunction : strapMode

  function automatic logic [3:0] pixWidth(input logic [5:0] dt, input rx_mode_t m);
    case (dt)
      DT_RAW8, DT_YUV422_8: pixWidth = 4'd8;
      DT_RAW10, DT_YUV420_10, DT_YUV420_10C, DT_YUV422_10: pixWidth = 4'd10;
      default: pixWidth = (m == ten_bit_mode) ? 4'd10 : 4'd12;
    endcase
  endfunction : pixWidth

  function automatic logic [31:0] shortPkt(input logic [1:0] vc, input logic [5:0] dt);
    shortPkt = {8'h00, 16'h0000, vc, dt};
  endfunction : shortPkt

  // ==========================================================
  // Frame crossing from the link clock
  logic [NPORT-1:0][FRAME_BITS-1:0] frame;
  logic [NPORT-1:0] frameStb;

  genvar g;
  generate
    for (g = 0; g < NPORT; g++) begin : gCdc
      rx_frame_cdc #(.W(FRAME_BITS)) uCdc (
        .linkClk(linkClk),
        .mclk(mclk),
        .rst_n(rst_n),
        .inFrame(rxFrame[g]),
        .inValid(rxFrameValid[g]),
        .outFrame(frame[g]),
        .outStrobe(frameStb[g])
      );
    end
  endgenerate

  // ==========================================================
  // Strap sampling after reset release
  logic [2:0] st1;
  logic [2:0] st2;
  logic [2:0] st3;
  logic strapDone;
  logic strapLoad;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st1 <= 3'h0;
      st2 <= 3'h0;
      st3 <= 3'h0;
    end else begin
      st1 <= modeStrap;
      st2 <= st1;
      st3 <= st2;
    end
  end

  logic [1:0] strapWait;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      strapWait <= 2'h0;
      strapDone <= 1'b0;
    end else if (!strapDone) begin
      if (strapWait != 2'h3) begin
        strapWait <= strapWait + 2'h1;
      end else if (st2 == st3) begin
        strapDone <= 1'b1;
      end
    end
  end

  assign strapLoad = !strapDone && strapWait == 2'h3 && st2 == st3 && strapValid(st3);

  // ==========================================================
  // Registers
  rx_mode_t [NPORT-1:0] mode;
  logic [NPORT-1:0][1:0] vc;
  logic [NPORT-1:0][5:0] dt;
  logic [7:0] fwdCtl;
  logic [7:0] csiCtl;
  logic [NPORT-1:0] frameAct;
  logic [NPORT-1:0] lineAct;
  logic portWr;

  assign portWr = regWrEn;

  generate
    for (g = 0; g < NPORT; g++) begin : gRegs
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          mode[g] <= MODE_RST;
        end else if (portWr && regPort == g && regAddr == ADDR_PORT_CFG) begin
          mode[g] <= rx_mode_t'(regWdata[MODE_LSB +: 2]);
        end else if (strapLoad) begin
          mode[g] <= strapMode(st3);
        end
      end

      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          vc[g] <= 2'(g);
          dt[g] <= DT_RST;
        end else if (portWr && regPort == g && regAddr == ADDR_PORT_VCDT) begin
          vc[g] <= regWdata[VC_LSB +: 2];
          dt[g] <= regWdata[5:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fwdCtl <= FWD_CTL_RST;
      csiCtl <= CSI_CTL_RST;
    end else if (portWr) begin
      if (regAddr == ADDR_FWD_CTL) begin
        fwdCtl <= regWdata;
      end
      if (regAddr == ADDR_CSI_CTL) begin
        csiCtl <= regWdata;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= 8'h00;
    end else begin
      case (regAddr)
        ADDR_PORT_CFG: regRdata <= {6'h00, mode[regPort]};
        ADDR_PORT_VCDT: regRdata <= {vc[regPort], dt[regPort]};
        ADDR_PORT_STS: regRdata <= {6'h00, lineAct[regPort], frameAct[regPort]};
        ADDR_FWD_CTL: regRdata <= fwdCtl;
        ADDR_CSI_CTL: regRdata <= csiCtl;
        default: regRdata <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Per-port frame decode into pending packet words
  logic [NPORT-1:0] vsPend;
  logic [NPORT-1:0] hsPend;
  logic [NPORT-1:0] pixPend;
  logic [NPORT-1:0] vsStart;
  logic [NPORT-1:0][31:0] vsWord;
  logic [NPORT-1:0][31:0] hsWord;
  logic [NPORT-1:0][31:0] pixWord;
  logic [NPORT-1:0] pop;
  logic [NPORT-1:0] has;
  logic [NPORT-1:0][31:0] headWord;
  logic [NPORT-1:0] headIsHdr;

  generate
    for (g = 0; g < NPORT; g++) begin : gPort
      logic [1:0] sync;
      logic [11:0] raw;
      logic [11:0] pix;
      logic [3:0] w;

      always_comb begin
        if (mode[g] == ten_bit_mode) begin
          sync = frame[g][SYNC10_LSB +: 2];
          raw = {frame[g][9:0], 2'b00};
        end else begin
          sync = frame[g][SYNC12_LSB +: 2];
          raw = frame[g][11:0];
        end
        w = pixWidth(dt[g], mode[g]);
        case (w)
          4'd8: pix = {4'h0, raw[11:4]};
          4'd10: pix = {2'b00, raw[11:2]};
          default: pix = raw;
        endcase
      end

      // Every sync edge is taken with no hold-off between edges
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          frameAct[g] <= 1'b0;
          lineAct[g] <= 1'b0;
        end else if (frameStb[g]) begin
          lineAct[g] <= sync[0];
          frameAct[g] <= sync[1];
        end
      end

      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          vsPend[g] <= 1'b0;
          vsStart[g] <= 1'b0;
          vsWord[g] <= '0;
        end else if (frameStb[g] && sync[1] != frameAct[g]) begin
          vsPend[g] <= 1'b1;
          vsStart[g] <= sync[1];
          vsWord[g] <= shortPkt(vc[g], sync[1] ? DT_FS : DT_FE);
        end else if (pop[g] && vsPend[g] && (vsStart[g] || !hsPend[g])) begin
          vsPend[g] <= 1'b0;
        end
      end

      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          hsPend[g] <= 1'b0;
          hsWord[g] <= '0;
        end else if (frameStb[g] && sync[0] != lineAct[g]) begin
          hsPend[g] <= 1'b1;
          hsWord[g] <= shortPkt(vc[g], sync[0] ? DT_LS : DT_LE);
        end else if (pop[g] && hsPend[g] && !(vsPend[g] && vsStart[g])) begin
          hsPend[g] <= 1'b0;
        end
      end

      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          pixPend[g] <= 1'b0;
          pixWord[g] <= '0;
        end else if (frameStb[g] && sync == 2'b11) begin
          pixPend[g] <= 1'b1;
          pixWord[g] <= {14'h0000, vc[g], 4'h0, pix};
        end else if (pop[g] && !vsPend[g] && !hsPend[g]) begin
          pixPend[g] <= 1'b0;
        end
      end

      // Start packets lead, end packets trail the line end
      always_comb begin
        has[g] = vsPend[g] | hsPend[g] | pixPend[g];
        headIsHdr[g] = vsPend[g] | hsPend[g];
        if (vsPend[g] && (vsStart[g] || !hsPend[g])) begin
          headWord[g] = vsWord[g];
        end else if (hsPend[g]) begin
          headWord[g] = hsWord[g];
        end else begin
          headWord[g] = pixWord[g];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Forwarding arbiters
  logic repl;
  logic [NTX-1:0][NPORT-1:0] req;
  logic [NTX-1:0][1:0] rr;
  logic [NTX-1:0] gntValid;
  logic [NTX-1:0][1:0] gntIdx;

  assign repl = fwdCtl[REPL_BIT];

  always_comb begin
    logic [1:0] idx;
    idx = 2'h0;
    pop = '0;
    for (int t = 0; t < NTX; t++) begin
      gntValid[t] = 1'b0;
      gntIdx[t] = 2'h0;
      for (int p = 0; p < NPORT; p++) begin
        req[t][p] = has[p] && ((repl ? 1'b0 : fwdCtl[p]) == t[0]);
      end
      for (int k = NPORT - 1; k >= 0; k--) begin
        idx = 2'(rr[t] + 2'(k));
        if (req[t][idx]) begin
          gntValid[t] = 1'b1;
          gntIdx[t] = idx;
        end
      end
      if (gntValid[t]) begin
        pop[gntIdx[t]] = 1'b1;
      end
    end
  end

  generate
    for (g = 0; g < NTX; g++) begin : gRr
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          rr[g] <= 2'h0;
        end else if (gntValid[g]) begin
          rr[g] <= gntIdx[g] + 2'h1;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Output words
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx0Valid <= 1'b0;
      tx0IsHeader <= 1'b0;
      tx0Data <= 32'h00000000;
    end else begin
      tx0Valid <= gntValid[0];
      tx0IsHeader <= headIsHdr[gntIdx[0]];
      tx0Data <= headWord[gntIdx[0]];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx1Valid <= 1'b0;
      tx1IsHeader <= 1'b0;
      tx1Data <= 32'h00000000;
    end else if (repl) begin
      tx1Valid <= gntValid[0];
      tx1IsHeader <= headIsHdr[gntIdx[0]];
      tx1Data <= headWord[gntIdx[0]];
    end else begin
      tx1Valid <= gntValid[1];
      tx1IsHeader <= headIsHdr[gntIdx[1]];
      tx1Data <= headWord[gntIdx[1]];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx0LaneSel <= 2'h3;
      tx1LaneSel <= 2'h3;
      backChanRate <= BC_RATE_2M5;
    end else begin
      tx0LaneSel <= csiCtl[1:0];
      tx1LaneSel <= csiCtl[3:2];
      backChanRate <= BC_RATE_2M5;
    end
  end
endmodule : rx_csi2_hub

// [rx_csi2_hub_asserts.sv]
`timescale 1ns/100ps
module rx_csi2_hub_asserts
  import rx_hub_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic regWrEn,
  input wire logic [7:0] regAddr,
  input wire logic [1:0] regPort,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic tx0Valid,
  input wire logic tx0IsHeader,
  input wire logic [31:0] tx0Data,
  input wire logic tx1Valid,
  input wire logic tx1IsHeader,
  input wire logic [31:0] tx1Data,
  input wire logic [1:0] tx0LaneSel,
  input wire logic [1:0] tx1LaneSel,
  input wire logic [2:0] backChanRate
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic replOn;
  logic mapped;
  logic [1:0] wLo;
  logic [1:0] wHi;
  assign wLo = regWdata[1:0];
  assign wHi = regWdata[3:2];
  assign mapped = regAddr inside {ADDR_FWD_CTL, ADDR_CSI_CTL, ADDR_PORT_STS, ADDR_PORT_CFG,
    ADDR_PORT_VCDT};
  // ==========================================================
  // Replicate setting as written on the register port
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      replOn <= 1'b0;
    end else if (regWrEn && regAddr == ADDR_FWD_CTL) begin
      replOn <= regWdata[REPL_BIT];
    end
  end
  // ==========================================================
  // Checks
  chk_rate_fixed: assert property (backChanRate == BC_RATE_2M5)
    else $error("back channel rate code wrong");
  chk_hdr0_form: assert property (tx0Valid && tx0IsHeader |-> tx0Data[31:8] == 24'h0 && tx0Data[5:2] == 4'h0)
    else $error("tx0 short packet malformed");
  chk_hdr1_form: assert property (tx1Valid && tx1IsHeader |-> tx1Data[31:8] == 24'h0 && tx1Data[5:2] == 4'h0)
    else $error("tx1 short packet malformed");
  chk_pix_form: assert property (tx0Valid && !tx0IsHeader |-> tx0Data[31:18] == 14'h0 && tx0Data[15:12] == 4'h0)
    else $error("tx0 pixel word malformed");
  chk_repl_copy: assert property ($past(replOn) && tx0Valid |-> tx1Valid && tx1Data == tx0Data)
    else $error("tx1 does not copy tx0");
  chk_lane0_set: assert property (regWrEn && regAddr == ADDR_CSI_CTL |-> ##2 tx0LaneSel == $past(wLo, 2))
    else $error("tx0 lane count not applied");
  chk_lane1_set: assert property (regWrEn && regAddr == ADDR_CSI_CTL |-> ##2 tx1LaneSel == $past(wHi, 2))
    else $error("tx1 lane count not applied");
  chk_unmapped_zero: assert property (!mapped |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  chk_mode_readback: assert property (regWrEn && regAddr == ADDR_PORT_CFG ##1 (!regWrEn && regAddr == ADDR_PORT_CFG && $stable(regPort)) |=> regRdata[1:0] == $past(wLo, 2))
    else $error("mode field readback wrong");
endmodule : rx_csi2_hub_asserts

// [sensor_link_model.sv]
`timescale 1ns/100ps
module sensor_link_model
  import rx_hub_pkg::*;
(
  input wire logic linkClk,
  output logic [NPORT-1:0][FRAME_BITS-1:0] rxFrame,
  output logic [NPORT-1:0] rxFrameValid
);
  initial begin
    rxFrame = '0;
    rxFrameValid = '0;
  end
  // ==========================================================
  // One frame every three link cycles (seven when tenBit); sy is {tenBit, frameSync, lineSync}
  task automatic send(input int p, input logic [2:0] sy, input logic [11:0] px);
    logic [FRAME_BITS-1:0] f;
    f = sy[2] ? {16'h0, sy[1:0], px[9:0]} : {14'h0, sy[1:0], px};
    @(posedge linkClk);
    rxFrame[p] <= f;
    rxFrameValid[p] <= 1'b1;
    @(posedge linkClk);
    rxFrame[p] <= ~f;
    rxFrameValid[p] <= 1'b0;
    repeat (sy[2] ? 5 : 1) @(posedge linkClk);
  endtask : send
endmodule : sensor_link_model

// [quad_rx_to_csi2_aggregator_test.sv]
`timescale 1ns/100ps
module quad_rx_to_csi2_aggregator_test;
  import rx_hub_pkg::*;
  logic mclk = 1'b0;
  logic linkClk = 1'b0;
  logic rst_n = 1'b0;
  logic [NPORT-1:0][FRAME_BITS-1:0] rxFrame;
  logic [NPORT-1:0] rxFrameValid;
  logic [2:0] modeStrap = 3'h0;
  logic regWrEn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [1:0] regPort = 2'h0;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] regRdata;
  logic tx0Valid, tx0IsHeader, tx1Valid, tx1IsHeader;
  logic [31:0] tx0Data, tx1Data;
  logic [1:0] tx0LaneSel, tx1LaneSel;
  logic [2:0] backChanRate;
  logic [7:0] v;
  logic [32:0] got0[$], got1[$], exp0[$], exp1[$];
  int bad_count = 0;
  int checked = 0;
  logic [1:0] strapMode [8] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h0, 2'h0, 2'h1, 2'h2};
  logic [1:0] modeSet [4] = '{2'h0, 2'h2, 2'h1, 2'h1};

  always #2 mclk = ~mclk;
  initial begin
    #1.3;
    forever #62.5 linkClk = ~linkClk;
  end

  rx_csi2_hub DUT (.mclk(mclk), .rst_n(rst_n), .linkClk(linkClk), .rxFrame(rxFrame),
    .rxFrameValid(rxFrameValid), .modeStrap(modeStrap), .regWrEn(regWrEn), .regAddr(regAddr),
    .regPort(regPort), .regWdata(regWdata), .regRdata(regRdata), .tx0Valid(tx0Valid),
    .tx0IsHeader(tx0IsHeader), .tx0Data(tx0Data), .tx1Valid(tx1Valid),
    .tx1IsHeader(tx1IsHeader), .tx1Data(tx1Data), .tx0LaneSel(tx0LaneSel),
    .tx1LaneSel(tx1LaneSel), .backChanRate(backChanRate));
  sensor_link_model u_sen (.linkClk(linkClk), .rxFrame(rxFrame), .rxFrameValid(rxFrameValid));

  // ==========================================================
  // Output word capture
  always @(posedge mclk) begin
    if (tx0Valid === 1'b1) got0.push_back({tx0IsHeader, tx0Data});
    if (tx1Valid === 1'b1) got1.push_back({tx1IsHeader, tx1Data});
  end

  // ==========================================================
  // Helpers
  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    checked++;
    if (seen !== want) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic give_verdict();
    $display("Mismatches %0d, comparisons %0d", bad_count, checked);
    if (bad_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic wr(input logic [7:0] a, input logic [1:0] p, input logic [7:0] d);
    @(posedge mclk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regPort <= p;
    regWdata <= d;
    @(posedge mclk);
    regWrEn <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [1:0] p, output logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regPort <= p;
    repeat (2) @(posedge mclk);
    #1 d = regRdata;
  endtask : rd

  task automatic doReset(input logic [2:0] s);
    @(posedge mclk);
    modeStrap <= s;
    rst_n <= 1'b0;
    repeat (2) @(posedge linkClk);
    @(posedge mclk);
    rst_n <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask : doReset

  function automatic logic [32:0] hw(input logic [1:0] vc, input logic [5:0] dt);
    return {1'b1, 24'h0, vc, dt};
  endfunction : hw

  function automatic logic [32:0] pw(input logic [1:0] vc, input logic [11:0] px);
    return {1'b0, 14'h0, vc, 4'h0, px};
  endfunction : pw

  task automatic waitCmp();
    int n;
    n = 0;
    while ((got0.size() < exp0.size() || got1.size() < exp1.size()) && n < 2000) begin
      @(posedge mclk);
      n++;
    end
    repeat (40) @(posedge mclk);
    check(33'(got0.size()), 33'(exp0.size()));
    check(33'(got1.size()), 33'(exp1.size()));
    foreach (exp0[k]) if (k < got0.size()) check(got0[k], exp0[k]);
    foreach (exp1[k]) if (k < got1.size()) check(got1[k], exp1[k]);
    got0 = {};
    got1 = {};
    exp0 = {};
    exp1 = {};
  endtask : waitCmp

  // ==========================================================
  // Test sequence
  initial begin
    for (int c = 0; c < 8; c++) begin
      doReset(3'(c));
      for (int p = 0; p < NPORT; p++) begin
        rd(ADDR_PORT_CFG, 2'(p), v);
        check(33'(v[1:0]), 33'(strapMode[c]));
      end
    end
    for (int p = 0; p < NPORT; p++) begin
      wr(ADDR_PORT_CFG, 2'(p), {6'h00, modeSet[p]});
      rd(ADDR_PORT_CFG, 2'(p), v);
      check(33'(v[1:0]), 33'(modeSet[p]));
      rd(ADDR_PORT_VCDT, 2'(p), v);
      check(33'(v), 33'({2'(p), DT_RST}));
    end
    wr(8'h01, 2'h0, 8'h5A);
    rd(ADDR_CSI_CTL, 2'h0, v);
    check(33'(v), 33'(CSI_CTL_RST));
    wr(ADDR_CSI_CTL, 2'h0, 8'h06);
    rd(ADDR_CSI_CTL, 2'h0, v);
    check(33'(v), 33'(8'h06));
    check(33'({tx1LaneSel, tx0LaneSel}), 33'(4'h6));
    rd(ADDR_FWD_CTL, 2'h0, v);
    check(33'(v), 33'(FWD_CTL_RST));
    check(33'(backChanRate), 33'(BC_RATE_2M5));
    wr(ADDR_PORT_VCDT, 2'h0, {2'h3, DT_YUV422_8});
    wr(ADDR_PORT_VCDT, 2'h1, {2'h1, DT_RAW10});
    wr(ADDR_FWD_CTL, 2'h0, 8'h02);
    // Line sync toggling on consecutive frames, frame sync held until the last
    u_sen.send(0, 3'b011, 12'hABC);
    u_sen.send(0, 3'b010, 12'h000);
    u_sen.send(0, 3'b011, 12'hDEF);
    u_sen.send(0, 3'b000, 12'h000);
    exp0 = {hw(2'h3, DT_FS), hw(2'h3, DT_LS), pw(2'h3, 12'h0AB), hw(2'h3, DT_LE),
      hw(2'h3, DT_LS), pw(2'h3, 12'h0DE), hw(2'h3, DT_LE), hw(2'h3, DT_FE)};
    waitCmp();
    u_sen.send(1, 3'b111, 12'h3A5);
    rd(ADDR_PORT_STS, 2'h1, v);
    check(33'(v), 33'(8'h03));
    u_sen.send(1, 3'b100, 12'h000);
    exp1 = {hw(2'h1, DT_FS), hw(2'h1, DT_LS), pw(2'h1, 12'h3A5), hw(2'h1, DT_LE),
      hw(2'h1, DT_FE)};
    waitCmp();
    wr(ADDR_FWD_CTL, 2'h0, 8'h10);
    u_sen.send(2, 3'b011, 12'h777);
    u_sen.send(2, 3'b000, 12'h000);
    exp0 = {hw(2'h2, DT_FS), hw(2'h2, DT_LS), pw(2'h2, 12'h777), hw(2'h2, DT_LE),
      hw(2'h2, DT_FE)};
    exp1 = exp0;
    waitCmp();
    give_verdict();
  end

  initial begin
    #100000;
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict();
  end
endmodule : quad_rx_to_csi2_aggregator_test

bind rx_csi2_hub rx_csi2_hub_asserts u_chk (.mclk(mclk), .rst_n(rst_n), .regWrEn(regWrEn),
  .regAddr(regAddr), .regPort(regPort), .regWdata(regWdata), .regRdata(regRdata),
  .tx0Valid(tx0Valid), .tx0IsHeader(tx0IsHeader), .tx0Data(tx0Data), .tx1Valid(tx1Valid),
  .tx1IsHeader(tx1IsHeader), .tx1Data(tx1Data), .tx0LaneSel(tx0LaneSel),
  .tx1LaneSel(tx1LaneSel), .backChanRate(backChanRate));
